// ### logic/load_relax_ctrl.v
// load model selection, current classification and relaxation control with APB registers
`timescale 1ns/100ps
`include "load_relax_map.vh"
// ------------------------------------------------------------
// Overview of operation
// - load model bit 0 selects constant current, 1 constant power; reset 0.
// - load model bit is mirrored in a status bit.
// - current model select 0 last-cycle average, 1 present-cycle average.
// - current select 2 average current, 3 filtered current with 14 s constant.
// - current select 4 design capacity over five, 5 hypothetical, 6 user rate.
// - power select 0 last-cycle power, 1 present-cycle power.
// - power select 2 current times voltage, 3 filtered current times voltage.
// - power select 4 design energy over five, 5 hypothetical, 6 user power.
// - reserve charge held in a register and driven out unchanged on o_reserve_charge.
// - reserve energy held in a register and driven out unchanged on o_reserve_energy.
// - discharge flagged only when magnitude exceeds discharge threshold.
// - charge flagged only when magnitude exceeds charge threshold.
// - relax entered after current below quit level for either relax time.
// - voltage readings attempted after about five minutes relaxed.
// - capacity learning also needs voltage slope below 4 uV per second.
// - relax left only after current at or above quit level for quit time.
// - two capacity values, seeded from initial value, updated during operation.
// - learned flag bit 0 of each profile status byte; other bits zero.
// ------------------------------------------------------------
module load_relax_ctrl #(
  parameter SEC_DIV = `CLK_HZ / `SEC_TICK_HZ,
  parameter OCV_WAIT = `OCV_WAIT_S,
  parameter TAU_S = `FILTER_TAU_S
) (
  input wire I_MCLK,
  input wire I_RST,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire signed [15:0] i_avg_current,
  input wire [15:0] i_voltage,
  input wire signed [15:0] i_avg_i_last,
  input wire signed [15:0] i_avg_i_now,
  input wire signed [15:0] i_avg_p_last,
  input wire signed [15:0] i_avg_p_now,
  input wire [15:0] i_dvdt_uv,
  input wire i_learn_valid,
  input wire [15:0] i_learn_value,
  output reg signed [31:0] o_load_rate,
  output reg o_load_mode,
  output reg o_relax,
  output reg o_dsg,
  output reg o_chg,
  output reg o_ocv_take,
  output reg o_learn_ok,
  output reg [15:0] o_reserve_charge,
  output reg [15:0] o_reserve_energy,
  output reg [15:0] o_chem_active
);
  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  reg load_mode_r;
  reg [2:0] load_sel_r;
  reg prof_r;
  reg [15:0] res_chg_r, res_nrg_r, dsg_th_r, chg_th_r, quit_r;
  reg [15:0] dsg_relax_r, chg_relax_r, quit_time_r;
  reg [15:0] user_i_r, user_p_r, design_cap_r, design_nrg_r, chem_init_r;
  reg signed [15:0] hypo_r;
  reg [15:0] chem_r [0:1];
  reg [1:0] upd_r;
  reg [31:0] div_r;
  reg tick_r;
  reg signed [31:0] filt_r;
  reg [15:0] below_cnt_r, above_cnt_r;
  reg [15:0] relax_cnt_r;
  wire wr = i_psel && i_penable && i_pwrite;
  wire [15:0] mag = i_avg_current[15] ? (~i_avg_current + 16'h0001) : i_avg_current;
  wire below = mag < quit_r;
  // ------------------------------------------------------------
  // apb slave, one wait-free access cycle
  // ------------------------------------------------------------
  reg [31:0] rd;
  always @* begin
    rd = 32'h00000000;
    case (i_paddr)
      `OFS_LOAD_CFG: rd = {23'h0, prof_r, 1'b0, load_sel_r, 3'h0, load_mode_r};
      `OFS_RESERVE: rd = {res_nrg_r, res_chg_r};
      `OFS_THRESH: rd = {chg_th_r, dsg_th_r};
      `OFS_QUIT_CUR: rd = {16'h0, quit_r};
      `OFS_RELAX_TIMES: rd = {chg_relax_r, dsg_relax_r};
      `OFS_QUIT_TIME: rd = {16'h0, quit_time_r};
      `OFS_RATES: rd = {user_p_r, user_i_r};
      `OFS_DESIGN: rd = {design_nrg_r, design_cap_r};
      `OFS_CHEM_INIT: rd = {16'h0, chem_init_r};
      `OFS_CHEM0: rd = {16'h0, chem_r[0]};
      `OFS_CHEM1: rd = {16'h0, chem_r[1]};
      `OFS_STATUS: rd = {15'h0, upd_r[1], 7'h0, upd_r[0], 2'h0, o_learn_ok, o_chg, o_dsg,
                         o_ocv_take, o_relax, load_mode_r};
      `OFS_LOAD_RATE: rd = o_load_rate;
      `OFS_HYPO_RATE: rd = {{16{hypo_r[15]}}, hypo_r};
      default: rd = 32'h00000000;
    endcase
  end
  wire unmapped = (i_paddr > `OFS_HYPO_RATE) || (i_paddr[1:0] != 2'b00);
  always @(posedge I_MCLK) begin
    if (I_RST) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && unmapped;
      if (i_psel && !i_penable) begin
        o_prdata <= rd;
      end
    end
  end
  wire wr_ok = wr && o_pready && !unmapped;
  always @(posedge I_MCLK) begin
    if (I_RST) begin
      load_mode_r <= `RST_LOAD_MODE;
      load_sel_r <= `RST_LOAD_SEL;
      prof_r <= 1'b0;
      res_chg_r <= `RST_RESERVE;
      res_nrg_r <= `RST_RESERVE;
      dsg_th_r <= `RST_DSG_TH;
      chg_th_r <= `RST_CHG_TH;
      quit_r <= `RST_QUIT_CUR;
      dsg_relax_r <= `RST_DSG_RELAX;
      chg_relax_r <= `RST_CHG_RELAX;
      quit_time_r <= `RST_QUIT_TIME;
      user_i_r <= `RST_RATE;
      user_p_r <= `RST_RATE;
      design_cap_r <= `RST_DESIGN;
      design_nrg_r <= `RST_DESIGN;
      chem_init_r <= `RST_CHEM;
      hypo_r <= 16'sh0000;
    end else if (wr_ok) begin
      case (i_paddr)
        `OFS_LOAD_CFG: begin
          load_mode_r <= i_pwdata[`CFG_MODE_BIT];
          load_sel_r <= i_pwdata[`CFG_SEL_HI:`CFG_SEL_LO];
          prof_r <= i_pwdata[`CFG_PROF_BIT];
        end
        `OFS_RESERVE: begin
          res_chg_r <= i_pwdata[15:0];
          res_nrg_r <= i_pwdata[31:16];
        end
        `OFS_THRESH: begin
          dsg_th_r <= i_pwdata[15:0];
          chg_th_r <= i_pwdata[31:16];
        end
        `OFS_QUIT_CUR: quit_r <= i_pwdata[15:0];
        `OFS_RELAX_TIMES: begin
          dsg_relax_r <= i_pwdata[15:0];
          chg_relax_r <= i_pwdata[31:16];
        end
        `OFS_QUIT_TIME: quit_time_r <= i_pwdata[15:0];
        `OFS_RATES: begin
          user_i_r <= i_pwdata[15:0];
          user_p_r <= i_pwdata[31:16];
        end
        `OFS_DESIGN: begin
          design_cap_r <= i_pwdata[15:0];
          design_nrg_r <= i_pwdata[31:16];
        end
        `OFS_CHEM_INIT: chem_init_r <= i_pwdata[15:0];
        `OFS_HYPO_RATE: hypo_r <= i_pwdata[15:0];
        default: hypo_r <= hypo_r;
      endcase
    end
  end
  // ------------------------------------------------------------
  // one-second tick and 14 s low-pass filter
  // ------------------------------------------------------------
  always @(posedge I_MCLK) begin
    if (I_RST) begin
      div_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == SEC_DIV - 1);
      div_r <= (div_r == SEC_DIV - 1) ? 32'h00000000 : div_r + 32'h00000001;
    end
  end
  // first-order filter, state scaled by TAU_S
  wire signed [31:0] filt_out = filt_r / TAU_S;
  always @(posedge I_MCLK) begin
    if (I_RST) begin
      filt_r <= 32'sh00000000;
    end else if (tick_r) begin
      filt_r <= filt_r - filt_out + {{16{i_avg_current[15]}}, i_avg_current};
    end
  end
  // ------------------------------------------------------------
  // load rate source selection
  // ------------------------------------------------------------
  wire signed [31:0] ai = {{16{i_avg_current[15]}}, i_avg_current};
  wire signed [31:0] v32 = {16'h0, i_voltage};
  reg signed [31:0] rate_nxt;
  always @* begin
    rate_nxt = 32'sh00000000;
    if (!load_mode_r) begin
      case (load_sel_r)
        3'h0: rate_nxt = {{16{i_avg_i_last[15]}}, i_avg_i_last};
        3'h1: rate_nxt = {{16{i_avg_i_now[15]}}, i_avg_i_now};
        3'h2: rate_nxt = ai;
        3'h3: rate_nxt = filt_out;
        3'h4: rate_nxt = {16'h0, design_cap_r} / 5;
        3'h5: rate_nxt = {{16{hypo_r[15]}}, hypo_r};
        3'h6: rate_nxt = {16'h0, user_i_r};
        default: rate_nxt = {{16{i_avg_i_now[15]}}, i_avg_i_now};
      endcase
    end else begin
      case (load_sel_r)
        3'h0: rate_nxt = {{16{i_avg_p_last[15]}}, i_avg_p_last};
        3'h1: rate_nxt = {{16{i_avg_p_now[15]}}, i_avg_p_now};
        3'h2: rate_nxt = ai * v32;
        3'h3: rate_nxt = filt_out * v32;
        3'h4: rate_nxt = {16'h0, design_nrg_r} / 5;
        3'h5: rate_nxt = {{16{hypo_r[15]}}, hypo_r};
        3'h6: rate_nxt = {16'h0, user_p_r};
        default: rate_nxt = {{16{i_avg_p_now[15]}}, i_avg_p_now};
      endcase
    end
  end
  // ------------------------------------------------------------
  // classification and relaxation state machine
  // ------------------------------------------------------------
  localparam ST_FLOW = 2'b01;
  localparam ST_RELAX = 2'b10;
  reg [1:0] state_r;
  wire enter_ok = (below_cnt_r >= dsg_relax_r) || (below_cnt_r >= chg_relax_r);
  always @(posedge I_MCLK) begin
    if (I_RST) begin
      state_r <= ST_FLOW;
      below_cnt_r <= 16'h0000;
      above_cnt_r <= 16'h0000;
      relax_cnt_r <= 16'h0000;
    end else if (tick_r) begin
      case (state_r)
        ST_FLOW: begin
          relax_cnt_r <= 16'h0000;
          above_cnt_r <= 16'h0000;
          if (!below) begin
            below_cnt_r <= 16'h0000;
          end else if (enter_ok) begin
            state_r <= ST_RELAX;
          end else begin
            below_cnt_r <= below_cnt_r + 16'h0001;
          end
        end
        ST_RELAX: begin
          below_cnt_r <= 16'h0000;
          if (relax_cnt_r != 16'hFFFF) begin
            relax_cnt_r <= relax_cnt_r + 16'h0001;
          end
          if (below) begin
            above_cnt_r <= 16'h0000;
          end else if (above_cnt_r + 16'h0001 >= quit_time_r) begin
            state_r <= ST_FLOW;
          end else begin
            above_cnt_r <= above_cnt_r + 16'h0001;
          end
        end
        default: state_r <= ST_FLOW;
      endcase
    end
  end
  wire ocv_nxt = (state_r == ST_RELAX) && (relax_cnt_r >= OCV_WAIT);
  wire learn_nxt = ocv_nxt && (i_dvdt_uv < `SLOPE_LIMIT_UV);
  // ------------------------------------------------------------
  // capacity store and learned flags
  // ------------------------------------------------------------
  always @(posedge I_MCLK) begin
    if (I_RST) begin
      chem_r[0] <= `RST_CHEM;
      chem_r[1] <= `RST_CHEM;
      upd_r <= 2'b00;
    end else begin
      if (wr_ok && i_paddr == `OFS_CHEM_INIT) begin
        chem_r[0] <= i_pwdata[15:0];
        chem_r[1] <= i_pwdata[15:0];
        upd_r <= 2'b00;
      end
      // a learn event in the seeding cycle wins over seed and clear
      if (learn_nxt && i_learn_valid) begin
        chem_r[prof_r] <= i_learn_value;
        upd_r[prof_r] <= 1'b1;
      end
    end
  end
  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always @(posedge I_MCLK) begin
    if (I_RST) begin
      o_load_rate <= 32'sh00000000;
      o_load_mode <= 1'b0;
      o_relax <= 1'b0;
      o_dsg <= 1'b0;
      o_chg <= 1'b0;
      o_ocv_take <= 1'b0;
      o_learn_ok <= 1'b0;
      o_reserve_charge <= `RST_RESERVE;
      o_reserve_energy <= `RST_RESERVE;
      o_chem_active <= `RST_CHEM;
    end else begin
      o_load_rate <= rate_nxt;
      o_load_mode <= load_mode_r;
      o_relax <= (state_r == ST_RELAX);
      o_dsg <= i_avg_current[15] && (mag > dsg_th_r);
      o_chg <= !i_avg_current[15] && (mag > chg_th_r);
      o_ocv_take <= ocv_nxt;
      o_learn_ok <= learn_nxt;
      o_reserve_charge <= res_chg_r;
      o_reserve_energy <= res_nrg_r;
      o_chem_active <= chem_r[prof_r];
    end
  end
endmodule

// ### logic/load_relax_map.vh
// register map, field positions, reset values and timing counts of the load/relax control
`ifndef LOAD_RELAX_MAP_VH
`define LOAD_RELAX_MAP_VH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define OFS_LOAD_CFG 12'h000
`define OFS_RESERVE 12'h004
`define OFS_THRESH 12'h008
`define OFS_QUIT_CUR 12'h00C
`define OFS_RELAX_TIMES 12'h010
`define OFS_QUIT_TIME 12'h014
`define OFS_RATES 12'h018
`define OFS_DESIGN 12'h01C
`define OFS_CHEM_INIT 12'h020
`define OFS_CHEM0 12'h024
`define OFS_CHEM1 12'h028
`define OFS_STATUS 12'h02C
`define OFS_LOAD_RATE 12'h030
`define OFS_HYPO_RATE 12'h034
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CFG_MODE_BIT 0
`define CFG_SEL_LO 4
`define CFG_SEL_HI 6
`define CFG_PROF_BIT 8
`define ST_LOAD_MODE_BIT 0
`define ST_RELAX_BIT 1
`define ST_OCV_BIT 2
`define ST_DSG_BIT 3
`define ST_CHG_BIT 4
`define ST_LEARN_BIT 5
`define ST_UPD0_BIT 8
`define ST_UPD1_BIT 16
`define UPD_LEARNED_MASK 8'h01
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_LOAD_MODE 1'b0
`define RST_LOAD_SEL 3'h1
`define RST_CHEM 16'h03E8
`define RST_DSG_TH 16'h003C
`define RST_CHG_TH 16'h004B
`define RST_QUIT_CUR 16'h0028
`define RST_DSG_RELAX 16'h003C
`define RST_CHG_RELAX 16'h003C
`define RST_QUIT_TIME 16'h0001
`define RST_RESERVE 16'h0000
`define RST_RATE 16'h0000
`define RST_DESIGN 16'h03E8
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_HZ 200000000
`define SEC_TICK_HZ 1
`define OCV_WAIT_MIN 5
`define OCV_WAIT_S (`OCV_WAIT_MIN * 60)
`define FILTER_TAU_S 14
`define SLOPE_LIMIT_UV 16'h0004
`endif

// ### tb/load_relax_props.sv
// assertion checker on the ports of the load/relax control
`timescale 1ns/100ps
module load_relax_props (
  input wire I_MCLK,
  input wire I_RST,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire signed [15:0] i_avg_current,
  input wire [15:0] i_dvdt_uv,
  input wire o_load_mode,
  input wire o_relax,
  input wire o_dsg,
  input wire o_chg,
  input wire o_ocv_take,
  input wire o_learn_ok
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  wire acc = i_psel && i_penable && o_pready;
  wire bad = (i_paddr > 12'h034) || (i_paddr[1:0] != 2'b00);
  a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("ready outside access");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (acc && bad |-> o_pslverr)
    else $error("no error on unmapped access");
  a_err_read_zero: assert property (acc && bad && !i_pwrite |-> o_prdata == 32'h0)
    else $error("unmapped read not zero");
  a_dsg_sign: assert property (o_dsg |-> $past(i_avg_current) < 0)
    else $error("discharge flag without discharge");
  a_chg_sign: assert property (o_chg |-> $past(i_avg_current) > 0)
    else $error("charge flag without charge");
  a_mode_mirror: assert property (acc && !i_pwrite && i_paddr == 12'h02C |->
    o_prdata[0] == o_load_mode) else $error("status mode bit differs");
  a_learn_slope: assert property (o_learn_ok |-> $past(i_dvdt_uv) < 16'h0004)
    else $error("learning with steep slope");
  a_ocv_after_relax: assert property ($rose(o_ocv_take) |-> $past(o_relax, 3))
    else $error("voltage reading too early");
endmodule
bind load_relax_ctrl load_relax_props load_relax_props_i (.I_MCLK, .I_RST, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_pready, .o_pslverr, .i_avg_current,
  .i_dvdt_uv, .o_load_mode, .o_relax, .o_dsg, .o_chg, .o_ocv_take, .o_learn_ok);

// ### tb/gauge_host.sv
// host model: APB master that writes and reads the gauge settings
`timescale 1ns/100ps
module gauge_host (
  input wire i_clk,
  input wire i_pready,
  input wire [31:0] i_prdata,
  input wire i_pslverr,
  output reg o_psel = 1'b0,
  output reg o_penable = 1'b0,
  output reg o_pwrite = 1'b0,
  output reg [11:0] o_paddr = 12'h000,
  output reg [31:0] o_pwdata = 32'h0,
  output reg o_hang = 1'b0
);
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q, output e);
    integer n;
    begin
      @(posedge i_clk);
      o_psel <= 1'b1;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_clk);
      o_penable <= 1'b1;
      n = 0;
      do begin
        @(posedge i_clk);
        n = n + 1;
      end while (i_pready !== 1'b1 && n < 16);
      if (n >= 16) o_hang <= 1'b1;
      q = i_prdata;
      e = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      // released lines show no stale value
      o_paddr <= ~a;
      o_pwdata <= ~d;
    end
  endtask
endmodule

// ### tb/load_model_relax_control_test.sv
// self-checking bench of the load/relax control block
`timescale 1ns/100ps
module load_model_relax_control_test;
  reg I_MCLK = 1'b0;
  reg I_RST = 1'b1;
  reg signed [15:0] cur = 16'sh0, il = 16'sh0, inow = 16'sh0, pl = 16'sh0, pn = 16'sh0;
  reg [15:0] volt = 16'h0E10, dvdt = 16'h0009, lval = 16'h0500, dcap, deng, urc, urp, hyp;
  reg lv = 1'b0;
  reg e;
  reg [31:0] q;
  wire psel, pen, pwr, pready, perr, mode, relax, dsg, chg, open_circuit_voltage, learn, hang;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire signed [31:0] rate;
  wire [15:0] chem, rsv_c, rsv_e;
  integer fails = 0;
  integer n_checks = 0;
  integer seed = 38;
  integer m, s;
  always #2.5 I_MCLK = ~I_MCLK;
  gauge_host gauge_host_i (.i_clk(I_MCLK), .i_pready(pready), .i_prdata(prdata),
    .i_pslverr(perr), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr),
    .o_pwdata(pwdata), .o_hang(hang));
  load_relax_ctrl #(.SEC_DIV(10), .OCV_WAIT(3), .TAU_S(14)) load_relax_ctrl_i (
    .I_MCLK(I_MCLK), .I_RST(I_RST), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(perr), .i_avg_current(cur), .i_voltage(volt), .i_avg_i_last(il),
    .i_avg_i_now(inow), .i_avg_p_last(pl), .i_avg_p_now(pn), .i_dvdt_uv(dvdt),
    .i_learn_valid(lv), .i_learn_value(lval), .o_load_rate(rate), .o_load_mode(mode),
    .o_relax(relax), .o_dsg(dsg), .o_chg(chg), .o_ocv_take(open_circuit_voltage), .o_learn_ok(learn),
    .o_reserve_charge(rsv_c), .o_reserve_energy(rsv_e), .o_chem_active(chem));
  task print_verdict;
    begin
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge hang) begin
    fails = fails + 1;
    $display("mismatch at %0t: bus transfer timed out", $time);
    print_verdict;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    gauge_host_i.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input [11:0] a, input [31:0] exp);
    begin
      gauge_host_i.xfer(1'b0, a, 32'h0, q, e);
      chk(q, exp);
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge I_MCLK);
  endtask
  // waits for relax (w 0) or voltage reading (w 1) to reach v
  task wait_sig(input integer w, input v, input integer lim);
    integer n;
    begin
      n = 0;
      while ((w ? open_circuit_voltage : relax) !== v && n < lim) begin
        @(posedge I_MCLK);
        n = n + 1;
      end
      if (n >= lim) begin
        fails = fails + 1;
        $display("mismatch at %0t: wait timed out", $time);
        print_verdict;
      end
      chk(w ? open_circuit_voltage : relax, v);
    end
  endtask
  task cls(input signed [15:0] c, input [1:0] dc);
    begin
      @(posedge I_MCLK);
      cur <= c;
      wt(3);
      chk({dsg, chg}, dc);
    end
  endtask
  function [31:0] exp_rate(input integer md, input integer sl);
    case (sl)
      0: exp_rate = md ? {{16{pl[15]}}, pl} : {{16{il[15]}}, il};
      2, 3: exp_rate = md ? {{16{cur[15]}}, cur} * {16'h0, volt} : {{16{cur[15]}}, cur};
      4: exp_rate = md ? deng / 5 : dcap / 5;
      5: exp_rate = {16'h0, hyp};
      6: exp_rate = md ? urp : urc;
      default: exp_rate = md ? {{16{pn[15]}}, pn} : {{16{inow[15]}}, inow};
    endcase
  endfunction
  initial begin
    wt(2);
    I_RST <= 1'b0;
    rd(12'h000, 32'h00000010);
    rd(12'h024, 32'h000003E8);
    rd(12'h02C, 32'h0);
    wr(12'h038, 32'hFFFFFFFF);
    chk(e, 1);
    rd(12'h002, 32'h0);
    chk(e, 1);
    $display("test reset_map done");
    dcap = $random(seed);
    deng = $random(seed);
    urc = $random(seed);
    urp = $random(seed);
    hyp = $random(seed) & 16'h7FFF;
    wr(12'h018, {urp, urc});
    wr(12'h01C, {deng, dcap});
    wr(12'h034, {16'h0, hyp});
    for (m = 0; m < 2; m = m + 1)
      for (s = 0; s < 8; s = s + 1)
        if (s != 3) begin
          @(posedge I_MCLK);
          cur <= $random(seed);
          il <= $random(seed);
          inow <= $random(seed);
          pl <= $random(seed);
          pn <= $random(seed);
          volt <= 16'h0C00 + ($random(seed) & 16'h03FF);
          wr(12'h000, {25'h0, s[2:0], 3'h0, m[0]});
          wt(3);
          chk(rate, exp_rate(m, s));
          chk(mode, m);
        end
    // filtered source: a steady input settles to itself
    @(posedge I_MCLK);
    cur <= -16'sd300;
    for (m = 0; m < 2; m = m + 1) begin
      wr(12'h000, {25'h0, 3'h3, 3'h0, m[0]});
      wt(2500);
      chk(rate, exp_rate(m, 3));
    end
    $display("test load_select done");
    wr(12'h004, 32'h01230456);
    wt(2);
    chk(rsv_c, 16'h0456);
    chk(rsv_e, 16'h0123);
    wr(12'h008, 32'h00C80064);
    cls(-16'sd101, 2'b10);
    cls(-16'sd100, 2'b00);
    cls(16'sd201, 2'b01);
    cls(16'sd200, 2'b00);
    $display("test classify done");
    wr(12'h00C, 32'h00000028);
    wr(12'h010, 32'h00050003);
    wr(12'h014, 32'h00000002);
    cls(16'sd500, 2'b01);
    wait_sig(0, 1'b0, 200);
    cls(16'sd0, 2'b00);
    wt(17);
    cls(16'sd500, 2'b01);
    wt(10);
    cls(16'sd0, 2'b00);
    wt(22);
    chk(relax, 0);
    wait_sig(0, 1'b1, 100);
    wait_sig(1, 1'b1, 100);
    lv <= 1'b1;
    wt(4);
    chk(learn, 0);
    chk(chem, 16'h03E8);
    dvdt <= 16'h0002;
    wt(4);
    chk(learn, 1);
    chk(chem, 16'h0500);
    lv <= 1'b0;
    rd(12'h02C, 32'h00000127);
    cls(16'sd500, 2'b01);
    chk(relax, 1);
    wait_sig(0, 1'b0, 100);
    wr(12'h000, 32'h00000110);
    wt(2);
    chk(chem, 16'h03E8);
    wr(12'h020, 32'h00000700);
    rd(12'h024, 32'h00000700);
    rd(12'h02C, 32'h00000010);
    $display("test relax_learn done");
    print_verdict;
  end
endmodule
